// >>> common/seerh_pkg.sv
/*
  shared constants of the serial eeprom read/hold control block: opcodes,
  status bit positions, address widths and link timing.
  assumes both ends and the testbench import it whole.
*/
`default_nettype none
package seerh_pkg;
  // =========================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  // =========================================================
  // status register layout
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP0_BIT = 2;
  localparam int ST_BP1_BIT = 3;
  localparam int ST_WPEN_BIT = 7;
  localparam logic [7:0] ST_WRITABLE_MASK = 8'h8c;
  localparam logic [7:0] ST_RESET = 8'h00;
  // =========================================================
  // address and transfer sizes
  localparam int ADDR_BITS_SENT = 16;
  localparam int ADDR_BITS_SMALL = 10;
  localparam int ADDR_BITS_LARGE = 11;
  localparam int PAGE_BYTES = 32;
  // =========================================================
  // timing
  localparam int CLK_SYS_NS = 20;
  localparam int WRITE_TIME_US = 5;
  localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_SYS_NS;
  localparam int SCK_HALF_CYCLES = 4;
  localparam int FIFO_DEPTH = 16;
endpackage : seerh_pkg
`default_nettype wire

// >>> common/seerh_link_if.sv
/*
  the four-wire serial link plus pause pin between host end and eeprom end.
  assumes one host and one device; so has an output enable, the bench
  only notes when it is high; the host reads so_o directly.
*/
`default_nettype none
interface seerh_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic so_o;
  logic so_oe;
  modport host (output cs_n, output sck, output si, output hold_n, input so_o, input so_oe);
  modport dev (input cs_n, input sck, input si, input hold_n, output so_o, output so_oe);
endinterface : seerh_link_if
`default_nettype wire

// >>> design/seerh_fifo.sv
/*
  synchronous valid/ready fifo, width and depth as parameters.
  assumes a single clock and a power-of-two depth.
*/
`default_nettype none
module seerh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire logic [WIDTH-1:0] in_data, // word in
  input wire logic in_valid, // word offered
  output logic in_ready, // room left
  output logic [WIDTH-1:0] out_data, // word out
  output logic out_valid, // word present
  input wire logic out_ready // sink takes word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule : seerh_fifo
`default_nettype wire

// >>> design/seerh_dev.sv
/*
  eeprom end of the serial link: opcode decode, array and status reads,
  pause, write latch and self-timed write. array read bytes pass a 16-word fifo
  before the shifter.
  assumes link pins are asynchronous to clk_sys and sck is far slower.
*/
`default_nettype none
module seerh_dev
  import seerh_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_BITS_LARGE, // 10 or 11
  parameter int WRITE_WAIT = WRITE_CYCLES // internal write duration in clk_sys
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // power-on reset, synchronous
  seerh_link_if.dev link, // serial link
  output logic busy, // internal write running
  output logic [7:0] status // status register image
);
  localparam int DEPTH = 1 << ADDR_BITS;
  typedef enum logic [2:0] {
    SEERH_STANDBY = 3'b000,
    SEERH_OPCODE = 3'b001,
    SEERH_ADDR = 3'b010,
    SEERH_RDATA = 3'b011,
    SEERH_RSTAT = 3'b100,
    SEERH_WDATA = 3'b101,
    SEERH_IGNORE = 3'b110,
    SEERH_DONE = 3'b111
  } seerh_state_t;

  // =========================================================
  // pin synchronisers
  logic [3:0] pins_meta;
  logic [3:0] pins_sync;
  logic sck_prev;
  always_ff @(posedge clk_sys) begin
    pins_meta <= {link.cs_n, link.sck, link.si, link.hold_n};
    pins_sync <= pins_meta;
    sck_prev <= pins_sync[2];
  end
  wire cs_n_s = pins_sync[3];
  wire sck_s = pins_sync[2];
  wire si_s = pins_sync[1];
  wire hold_n_s = pins_sync[0];
  wire paused = !hold_n_s;
  wire sck_rise = sck_s && !sck_prev && !paused;
  wire sck_fall = !sck_s && sck_prev && !paused;

  // =========================================================
  // storage and status
  logic [7:0] mem [DEPTH];
  logic [7:0] page_buf [PAGE_BYTES];
  logic write_enable_latch;
  logic [7:0] st_nv;
  logic [WRITE_WAIT > 1 ? $clog2(WRITE_WAIT+1) : 1 :0] wr_cnt;
  assign busy = wr_cnt != '0;
  assign status = {st_nv[7:2], write_enable_latch, busy};

  seerh_state_t state;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [7:0] opcode;
  logic [ADDR_BITS_SENT-1:0] addr;
  logic [ADDR_BITS-1:0] rd_ptr;
  logic [ADDR_BITS-1:0] wr_addr;
  logic [5:0] nbytes;
  logic wr_pending;
  logic sr_pending;
  logic [7:0] sr_new;
  // so stays driven across byte seams once the first bit is out
  logic so_live;

  function automatic logic valid_op(input logic [7:0] op);
    valid_op = op inside {OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_STATUS_READ,
      OP_STATUS_WRITE, OP_ARRAY_READ, OP_ARRAY_WRITE};
  endfunction : valid_op

  wire [7:0] next_op = {shreg[6:0], si_s};
  wire op_done = sck_rise && bitcnt == 3'd7;
  wire array_ok = !busy;

  // =========================================================
  // read fifo: prefetch of array bytes ahead of the shifter
  logic [7:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic fifo_pop;
  logic fifo_push;
  logic fifo_flush;
  always_ff @(posedge clk_sys) begin
    fifo_flush <= reset || cs_n_s;
  end
  assign fifo_push = state == SEERH_RDATA && !cs_n_s;
  seerh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(fifo_flush),
    .in_data(mem[rd_ptr]),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  assign fifo_pop = state == SEERH_RDATA && sck_fall && bitcnt == 3'd0 && fifo_valid;

  // =========================================================
  // serial state machine
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= SEERH_STANDBY;
      write_enable_latch <= 1'b0;
      st_nv <= ST_RESET;
      wr_cnt <= '0;
      bitcnt <= '0;
      shreg <= '0;
      opcode <= '0;
      addr <= '0;
      rd_ptr <= '0;
      wr_addr <= '0;
      nbytes <= '0;
      wr_pending <= 1'b0;
      sr_pending <= 1'b0;
      sr_new <= '0;
      link.so_o <= 1'b0;
      so_live <= 1'b0;
    end else begin
      if (wr_cnt != '0) begin
        wr_cnt <= wr_cnt - 1'b1;
        if (wr_cnt == 1) begin
          write_enable_latch <= 1'b0;
          if (sr_pending) begin
            st_nv <= (st_nv & ~ST_WRITABLE_MASK) | (sr_new & ST_WRITABLE_MASK);
          end
          sr_pending <= 1'b0;
        end
      end
      if (fifo_push && fifo_in_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (cs_n_s) begin
        if (state == SEERH_WDATA && bitcnt == 3'd0 && nbytes != '0) begin
          wr_cnt <= $bits(wr_cnt)'(WRITE_WAIT);
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (i < nbytes) begin
              mem[{wr_addr[ADDR_BITS-1:5], 5'(wr_addr[4:0] + 5'(i))}] <= page_buf[i];
            end
          end
        end
        if (state == SEERH_DONE && bitcnt == 3'd0 && !busy) begin
          if (opcode == OP_WRITE_ENABLE) write_enable_latch <= 1'b1;
          if (opcode == OP_WRITE_DISABLE) write_enable_latch <= 1'b0;
          if (opcode == OP_STATUS_WRITE && sr_pending) wr_cnt <= $bits(wr_cnt)'(WRITE_WAIT);
        end
        if (!(state == SEERH_DONE && opcode == OP_STATUS_WRITE && bitcnt == 3'd0)) begin
          if (!busy) sr_pending <= 1'b0;
        end
        state <= SEERH_STANDBY;
        bitcnt <= '0;
        link.so_o <= 1'b0;
        so_live <= 1'b0;
      end else begin
        case (state)
          SEERH_STANDBY: begin
            state <= SEERH_OPCODE;
            bitcnt <= '0;
            nbytes <= '0;
          end
          SEERH_OPCODE: begin
            if (sck_rise) begin
              shreg <= next_op;
              bitcnt <= bitcnt + 1'b1;
            end
            if (op_done) begin
              opcode <= next_op;
              if (!valid_op(next_op)) begin
                state <= SEERH_IGNORE;
              end else if (next_op == OP_STATUS_READ) begin
                state <= SEERH_RSTAT;
                shreg <= status;
              end else if (next_op == OP_ARRAY_READ || next_op == OP_ARRAY_WRITE) begin
                state <= array_ok ? SEERH_ADDR : SEERH_IGNORE;
                addr <= '0;
              end else if (next_op == OP_STATUS_WRITE) begin
                state <= (busy || !write_enable_latch) ? SEERH_IGNORE : SEERH_WDATA;
              end else begin
                state <= busy ? SEERH_IGNORE : SEERH_DONE;
              end
            end
          end
          SEERH_ADDR: begin
            if (sck_rise) begin
              addr <= {addr[ADDR_BITS_SENT-2:0], si_s};
              bitcnt <= bitcnt + 1'b1;
              if (bitcnt == 3'd7 && addr[6:0] != 7'h00 || bitcnt == 3'd7 && addr[14]) begin
                bitcnt <= bitcnt + 1'b1;
              end
            end
            if (sck_rise && nbytes == 6'd1 && bitcnt == 3'd7) begin
              rd_ptr <= ADDR_BITS'({addr[ADDR_BITS_SENT-2:0], si_s});
              wr_addr <= ADDR_BITS'({addr[ADDR_BITS_SENT-2:0], si_s});
              nbytes <= '0;
              if (opcode == OP_ARRAY_READ) begin
                state <= SEERH_RDATA;
              end else begin
                state <= write_enable_latch ? SEERH_WDATA : SEERH_IGNORE;
              end
            end else if (sck_rise && bitcnt == 3'd7) begin
              nbytes <= 6'd1;
            end
          end
          SEERH_RDATA: begin
            if (fifo_pop) begin
              link.so_o <= fifo_out[7];
              so_live <= 1'b1;
              shreg <= {fifo_out[6:0], 1'b0};
              bitcnt <= 3'd1;
            end else if (sck_fall && bitcnt != 3'd0) begin
              link.so_o <= shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 1'b1;
            end
          end
          SEERH_RSTAT: begin
            if (sck_fall) begin
              link.so_o <= shreg[7];
              so_live <= 1'b1;
              shreg <= bitcnt == 3'd7 ? status : {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 1'b1;
            end
          end
          SEERH_WDATA: begin
            if (sck_rise) begin
              shreg <= next_op;
              bitcnt <= bitcnt + 1'b1;
              if (bitcnt == 3'd7) begin
                if (opcode == OP_STATUS_WRITE) begin
                  sr_new <= next_op;
                  sr_pending <= 1'b1;
                  state <= SEERH_DONE;
                end else begin
                  page_buf[nbytes[4:0]] <= next_op;
                  if (nbytes != 6'(PAGE_BYTES)) nbytes <= nbytes + 1'b1;
                end
              end
            end
          end
          SEERH_DONE: begin
            if (sck_rise) bitcnt <= bitcnt + 1'b1;
          end
          default: begin
            state <= SEERH_IGNORE;
          end
        endcase
      end
    end
  end
  assign link.so_oe = !cs_n_s && hold_n_s && so_live
    && (state == SEERH_RDATA || state == SEERH_RSTAT);
endmodule : seerh_dev
`default_nettype wire

// >>> design/seerh_host.sv
/*
  host end: runs one transaction per command, making sck from clk_sys by
  a divider, and returns read bytes on a one-cycle strobe.
  assumes the user holds cmd fields stable while cmd_valid is high.
*/
`default_nettype none
module seerh_host
  import seerh_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES // clk_sys cycles per sck half
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  seerh_link_if.host link, // serial link
  input wire logic cmd_valid, // start a transaction
  output logic cmd_ready, // idle, command taken
  input wire logic [7:0] cmd_op, // opcode to send
  input wire logic [15:0] cmd_addr, // address, sent when the opcode needs one
  input wire logic [7:0] cmd_wdata, // data byte sent after header
  input wire logic [5:0] cmd_len, // bytes to read or write after header
  input wire logic pause, // request hold while active
  output logic [7:0] rd_data, // byte read
  output logic rd_strobe // rd_data new, one cycle
);
  typedef enum logic [1:0] {
    SEERH_H_IDLE = 2'b00,
    SEERH_H_SHIFT = 2'b01,
    SEERH_H_END = 2'b10
  } seerh_hstate_t;
  seerh_hstate_t state;
  logic [$clog2(HALF+1)-1:0] div;
  logic [8:0] nbits;
  logic [31:0] tx;
  logic [7:0] rx;
  logic so_meta;
  logic so_sync;
  logic held;
  wire tick = div == '0;
  wire needs_addr = cmd_op == OP_ARRAY_READ || cmd_op == OP_ARRAY_WRITE;
  wire [8:0] hdr_bits = needs_addr ? 9'd24 : 9'd8;
  assign cmd_ready = state == SEERH_H_IDLE;
  always_ff @(posedge clk_sys) begin
    so_meta <= link.so_o;
    so_sync <= so_meta;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= SEERH_H_IDLE;
      link.cs_n <= 1'b1;
      link.sck <= 1'b0;
      link.si <= 1'b0;
      link.hold_n <= 1'b1;
      div <= '0;
      nbits <= '0;
      tx <= '0;
      rx <= '0;
      held <= 1'b0;
      rd_data <= '0;
      rd_strobe <= 1'b0;
    end else begin
      rd_strobe <= 1'b0;
      div <= tick ? ($bits(div))'(HALF - 1) : div - 1'b1;
      case (state)
        SEERH_H_IDLE: begin
          if (cmd_valid) begin
            link.cs_n <= 1'b0;
            tx <= needs_addr ? {cmd_op, cmd_addr, cmd_wdata} : {cmd_op, cmd_wdata, 16'h0000};
            nbits <= hdr_bits + 9'(cmd_len) * 9'd8;
            state <= SEERH_H_SHIFT;
            div <= ($bits(div))'(HALF - 1);
          end
        end
        SEERH_H_SHIFT: begin
          if (tick && !link.sck) begin
            link.hold_n <= !pause;
            held <= pause;
            // resume raises hold alone; sck waits one more tick
            if (!pause && !held) begin
              link.si <= tx[31];
              link.sck <= 1'b1;
            end
          end else if (tick && link.sck) begin
            link.sck <= 1'b0;
            rx <= {rx[6:0], so_sync};
            tx <= {tx[30:0], tx[7]};
            nbits <= nbits - 1'b1;
            if (nbits <= 9'(cmd_len) * 9'd8 && nbits[2:0] == 3'd1) begin
              rd_data <= {rx[6:0], so_sync};
              rd_strobe <= 1'b1;
            end
            if (nbits == 9'd1) state <= SEERH_H_END;
          end
        end
        SEERH_H_END: begin
          if (tick) begin
            link.cs_n <= 1'b1;
            state <= SEERH_H_IDLE;
          end
        end
        default: begin
          state <= SEERH_H_IDLE;
        end
      endcase
    end
  end
endmodule : seerh_host
`default_nettype wire

// >>> verif/seerh_link_checker.sv
/*
  checker of the serial link between host end and eeprom end.
  assumes clk_sys samples every link wire, sck half period of 4 cycles.
*/
`default_nettype none
module seerh_link_checker (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire logic cs_n, // select, active low
  input wire logic sck, // link clock
  input wire logic si, // host to device data
  input wire logic hold_n, // pause, active low
  input wire logic so_o, // device to host data
  input wire logic so_oe // device drives so
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // link relations
  a_reset_leaves_idle: assert property ($fell(reset) |-> cs_n && hold_n && !so_oe)
    else $error("link not idle after reset");
  a_deselect_releases_so: assert property (cs_n [*4] |-> !so_oe)
    else $error("so still driven after deselect");
  a_pause_releases_so: assert property (!hold_n [*4] |-> !so_oe)
    else $error("so driven during pause");
  a_pause_keeps_select: assert property (!hold_n |-> !cs_n)
    else $error("pause without select");
  a_hold_edge_sck_low: assert property ($changed(hold_n) |-> !sck && !$past(sck))
    else $error("hold moved while sck high");
  a_select_edge_mode: assert property ($fell(cs_n) || $rose(cs_n) |-> !sck && !$past(sck))
    else $error("select edge with sck high");
  a_idle_sck_still: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("sck runs while deselected");
  a_si_steady_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("si moved while sck high");
  a_so_steady_high: assert property (so_oe && $past(so_oe) && sck && $past(sck) |-> $stable(so_o))
    else $error("so moved while sck high");
  a_sck_high_time: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase wrong length");
endmodule : seerh_link_checker
`default_nettype wire

// >>> verif/spi_eeprom_read_hold_control_tb.sv
/*
  testbench: host end and eeprom end joined by the link; the read fifo is
  exercised through a stream longer than its depth.
  assumes the design files and seerh_pkg are compiled before this file.
*/
`default_nettype none
module spi_eeprom_read_hold_control_tb;
  import seerh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // long enough that a status poll lands inside the write
  localparam int WAIT_SIM = 1000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [7:0] cmd_op = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic [5:0] cmd_len = 6'h00;
  logic pause = 1'b0;
  logic [7:0] rd_data;
  logic rd_strobe;
  logic busy;
  logic [7:0] status;
  logic so_seen = 1'b0;
  logic [7:0] got[$];
  logic [7:0] fdat[FIFO_DEPTH];
  logic [31:0] lfsr_state = 32'hd68e;
  logic [15:0] a;
  logic [7:0] d;
  int failures = 0;
  int checks_done = 0;
  seerh_link_if seerh_link_if_i ();
  seerh_host #(.HALF(SCK_HALF_CYCLES)) seerh_host_i (.clk_sys(clk_sys), .reset(reset),
    .link(seerh_link_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .pause(pause),
    .rd_data(rd_data), .rd_strobe(rd_strobe));
  seerh_dev #(.ADDR_BITS(ADDR_BITS_LARGE), .WRITE_WAIT(WAIT_SIM)) seerh_dev_i (
    .clk_sys(clk_sys), .reset(reset), .link(seerh_link_if_i), .busy(busy), .status(status));
  seerh_link_checker seerh_link_checker_i (.clk_sys(clk_sys), .reset(reset),
    .cs_n(seerh_link_if_i.cs_n), .sck(seerh_link_if_i.sck), .si(seerh_link_if_i.si),
    .hold_n(seerh_link_if_i.hold_n), .so_o(seerh_link_if_i.so_o), .so_oe(seerh_link_if_i.so_oe));
  // ==========================================================
  // clock, capture, watchdog
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rd_strobe === 1'b1) got.push_back(rd_data);
    if (seerh_link_if_i.so_oe === 1'b1) so_seen = 1'b1;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    check("run time", 8'h0, 8'h1);
    final_report();
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] st_exp(input logic write_enable_latch, input logic bsy, input logic [7:0] bp);
    return (bp & ST_WRITABLE_MASK) | (8'(write_enable_latch) << ST_WEL_BIT) | (8'(bsy) << ST_BUSY_BIT);
  endfunction : st_exp
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 20000) begin
        check("cmd_ready wait", 8'h0, 8'h1);
        final_report();
      end
    end
  endtask : wait_ready
  task automatic run(input logic [7:0] op, input logic [15:0] ad, input logic [7:0] wd,
                     input logic [5:0] len);
    wait_ready();
    got.delete();
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = wd;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    @(negedge clk_sys);
    wait_ready();
    // let the device see the deselect before the next select
    repeat (4) @(negedge clk_sys);
  endtask : run
  task automatic poll_done();
    int n;
    n = 0;
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    while (got[0][ST_BUSY_BIT] !== 1'b0 && n < 40) begin
      run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
      n++;
    end
    check("write finish", got[0][ST_BUSY_BIT], 8'h0);
  endtask : poll_done
  task automatic write_bytes(input logic [15:0] ad, input logic [7:0] wd, input logic [5:0] len);
    run(OP_WRITE_ENABLE, 16'h0, 8'h0, 6'd0);
    run(OP_ARRAY_WRITE, ad, wd, len);
    check("busy after write", busy, 8'h1);
    poll_done();
  endtask : write_bytes
  task automatic pulse_reset();
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
  endtask : pulse_reset
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    check("busy at reset", busy, 8'h0);
    check("status at reset", status, ST_RESET);
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("first status read", got[0], st_exp(0, 0, 0));
    foreach (fdat[i]) begin
      fdat[i] = 8'(i * 37);
      so_seen = 1'b0;
      run(fdat[i] | 8'h08, 16'h0, 8'h0, 6'd1);
      check("bad opcode so", 8'(so_seen), 8'h0);
    end
    run(OP_WRITE_ENABLE, 16'h0, 8'h0, 6'd0);
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("latch set", got[0], st_exp(1, 0, 0));
    run(OP_WRITE_DISABLE, 16'h0, 8'h0, 6'd0);
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("latch cleared", got[0], st_exp(0, 0, 0));
    run(OP_WRITE_ENABLE, 16'h0, 8'h0, 6'd0);
    pulse_reset();
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("latch after reset", got[0], st_exp(0, 0, 0));
    // busy window: status answers, array read stays silent
    run(OP_WRITE_ENABLE, 16'h0, 8'h0, 6'd0);
    run(OP_ARRAY_WRITE, 16'h0000, 8'h3c, 6'd2);
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("busy in status", got[0][ST_BUSY_BIT], 8'h1);
    so_seen = 1'b0;
    run(OP_ARRAY_READ, 16'h0000, 8'h0, 6'd1);
    check("read while busy", 8'(so_seen), 8'h0);
    poll_done();
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("latch after write", got[0], st_exp(0, 0, 0));
    for (int i = 0; i < 3; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      a = {6'h00, lfsr_state[9:0]} | 16'h0040;
      d = lfsr_state[23:16];
      write_bytes(a, d, 6'd1);
      run(OP_ARRAY_READ, {lfsr_state[31:27], a[10:0]}, 8'h0, 6'd1);
      check("random byte", got[0], d);
    end
    // top of array wraps to zero, with a pause in mid-read
    lfsr_state = lfsr_next(lfsr_state);
    d = lfsr_state[7:0];
    write_bytes(16'h07fe, d, 6'd2);
    fork
      run(OP_ARRAY_READ, 16'h07fe, 8'h0, 6'd4);
      begin
        repeat (260) @(negedge clk_sys);
        pause = 1'b1;
        repeat (60) @(negedge clk_sys);
        pause = 1'b0;
      end
    join
    for (int i = 0; i < 4; i++) begin
      check("wrap stream", got[i], (i < 2) ? d : 8'h3c);
    end
    run(OP_WRITE_ENABLE, 16'h0, 8'h0, 6'd0);
    run(OP_STATUS_WRITE, 16'h0, 8'hff, 6'd1);
    poll_done();
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("status write", got[0], st_exp(0, 0, 8'hff));
    // full page, then a stream that outruns the 16-word prefetch
    lfsr_state = lfsr_next(lfsr_state);
    d = lfsr_state[15:8];
    write_bytes(16'h0100, d, 6'd32);
    so_seen = 1'b0;
    run(OP_ARRAY_READ, 16'h0100, 8'h0, 6'd20);
    check("stream count", 8'(got.size()), 8'd20);
    check("stream so driven", 8'(so_seen), 8'h1);
    foreach (got[i]) begin
      check("stream word", got[i], d);
    end
    run(OP_STATUS_READ, 16'h0, 8'h0, 6'd1);
    check("status after stream", got[0], st_exp(0, 0, 8'hff));
    check("busy after stream", busy, 8'h0);
    final_report();
  end
endmodule : spi_eeprom_read_hold_control_tb
`default_nettype wire
